// file: src/rtw_core.sv
// Register window, BCD calendar and alarm of the clock calendar block.
//
// Behaviour
// [R1] The write-unlock bit changes only through the two-write unlock sequence; the code clears it on a single write of 00h.
// [R2] Read-only ripple flag is high while a rollover may corrupt reads.
// [R3] Read-only half-second bit; cleared when the seconds slot is written.
// [R4] Time pointer decrements on each high time window access, stops at zero.
// [R5] High time window: minutes, weekday, month, reserved.
// [R6] Low time window: seconds, hours, day, year.
// [R7] Reserved high slot reads zero but still decrements the pointer.
// [R8] Drift trim adds or drops four timebase pulses per code each minute.
// [R9] Second configuration register is cleared only by power-on reset.
// [R10] With chime set the repeat counter wraps from 00h to FFh.
// [R11] Repeat counter decrements on every alarm event.
// [R12] Without chime the repeat counter stops at 00h.
// [R13] Count FFh gives 255 repeats after the first; 00h gives none.
// [R14] Alarm slots are reached through windows indexed by the alarm pointer.
// [R15] Alarm pointer decrements on high alarm window access; code 11 unused.
// [R16] Year is two BCD digits, writable only while unlocked.
// [R17] Month, day, weekday and hour writes need the unlock bit set.
// [R18] Month: one tens bit at bit 4, ones in bits 3-0.
// [R19] Day: tens in bits 5-4, ones in bits 3-0, upper bits zero.
// [R20] Weekday: bits 2-0 from 0 to 6, upper bits zero.
// [R21] Hour: tens in bits 5-4, ones in bits 3-0, 24-hour time.
// [R22] Minute and second: tens in bits 6-4, ones in 3-0, bit 7 zero.
// [R23] Enable bit and time window writes are ignored while locked.
// [R24] Alarm windows map like the time windows, with slot 11 of both reserved.
// [R25] Alarm interval selectable from half second to year.
// [R26] BCD ones digits carry into tens at ten, not sixteen.
// [R27] Alarm enable clears itself after the last alarm without chime.
// [R28] Alarm mask codes ascend half second to month, 1001 yearly.
// [R29] Module enable runs timekeeping; output enable gates the output pin.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module rtw_core
	import rtw_pkg::*;
#(
	parameter int TICKS_PER_HALF = HALF_TICKS
) (
	// Clock and resets.
	input wire logic mclk,
	input wire logic rstn,
	input wire logic por_n,
	// Timebase input from the 32.768 kHz oscillator domain.
	input wire logic timebase_in,
	// Register port.
	input wire rtw_pkg::rtw_req_t req,
	output logic [7:0] rdata,
	// Pins and status.
	output logic clock_out,
	output logic alarm_pulse
);
	import rtw_pkg::*;

	typedef struct packed {
		logic [1:0] tb_sync;
		logic tb_prev;
		logic module_on;
		logic unlock;
		logic out_on;
		logic half;
		logic ripple;
		logic [1:0] tptr;
		logic [7:0] trim;
		logic [7:0] cfg_two;
		logic alarm_on;
		logic chime;
		logic [3:0] alarm_interval_mask;
		logic [1:0] aptr;
		logic [7:0] rpt;
		rtw_time_t tm;
		rtw_alarm_t al;
		logic [15:0] sub;
		logic [5:0] min_secs;
		rtw_unlock_t ul;
		logic [7:0] rdata;
		logic clock_out;
		logic alarm_pulse;
	} st_t;

	st_t s;
	st_t n;
	logic [7:0] cfg_two_q;

	// Increment one BCD byte with ones carry at ten; wrap to lo past hi.
	function automatic logic [7:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] r;
		r = v;
		if (v == hi) begin
			r = lo;
		end else if (v[3:0] == BCD_NINE) begin
			r = {v[7:4] + 4'h1, 4'h0}; // [R26]
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	// Last day of the month, with every fourth year a leap year.
	function automatic logic [7:0] month_end(input logic [7:0] mon,
		input logic [7:0] yr);
		logic [7:0] r;
		r = 8'h31;
		unique case (mon)
			8'h02: r = ((yr[4] ^ yr[1]) || yr[0]) ? 8'h28 : 8'h29;
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			default: r = 8'h31;
		endcase
		return r;
	endfunction

	logic tick;
	logic sec_tick;
	logic wr_th;
	logic wr_tl;
	logic acc_th;
	logic acc_ah;
	logic [15:0] half_len;
	logic [7:0] th_val;
	logic [7:0] tl_val;
	logic [7:0] ah_val;
	logic [7:0] al_val;
	logic match;
	logic [7:0] wv;

	always_comb begin
		n = s;
		wv = req.wdata;
		n.tb_sync = {s.tb_sync[0], timebase_in};
		n.tb_prev = s.tb_sync[1];
		tick = s.tb_sync[1] & ~s.tb_prev & s.module_on; // [R29]
		// Trim stretches or shortens the last half second of each minute.
		half_len = 16'(TICKS_PER_HALF) - 16'h1;
		if (s.min_secs == 6'd59 && s.half) begin
			half_len = 16'(half_len - 16'(signed'(s.trim)) * 16'(TRIM_STEP)); // [R8]
		end
		sec_tick = 1'b0;
		if (tick) begin
			if (s.sub >= half_len) begin
				n.sub = 16'h0;
				n.half = ~s.half;
				sec_tick = s.half;
			end else begin
				n.sub = s.sub + 16'h1;
			end
		end
		// Ripple flag covers the last timebase counts before a rollover.
		n.ripple = s.module_on && s.half && (s.sub + 16'h20 >= half_len); // [R2]
		if (sec_tick) begin
			n.min_secs = (s.min_secs == 6'd59) ? 6'd0 : s.min_secs + 6'd1;
			n.tm.second = bcd_inc(s.tm.second, 8'h00, 8'h59); // [R22]
			if (s.tm.second == 8'h59) begin
				n.tm.minute = bcd_inc(s.tm.minute, 8'h00, 8'h59);
				if (s.tm.minute == 8'h59) begin
					n.tm.hour = bcd_inc(s.tm.hour, 8'h00, 8'h23); // [R21]
					if (s.tm.hour == 8'h23) begin
						n.tm.weekday = bcd_inc(s.tm.weekday, 8'h00, 8'h06); // [R20]
						n.tm.day = bcd_inc(s.tm.day, RESET_DAY,
							month_end(s.tm.month, s.tm.year)); // [R19]
						if (s.tm.day == month_end(s.tm.month, s.tm.year)) begin
							n.tm.month = bcd_inc(s.tm.month, RESET_DAY, 8'h12); // [R18]
							if (s.tm.month == 8'h12) begin
								n.tm.year = bcd_inc(s.tm.year, 8'h00, 8'h99); // [R16]
							end
						end
					end
				end
			end
		end

		// Window read values.
		unique case (s.tptr)
			PTR_ZERO: th_val = s.tm.minute; // [R5]
			PTR_ONE: th_val = s.tm.weekday;
			PTR_TWO: th_val = s.tm.month;
			PTR_THREE: th_val = RESET_BYTE; // [R7]
		endcase
		unique case (s.tptr)
			PTR_ZERO: tl_val = s.tm.second; // [R6]
			PTR_ONE: tl_val = s.tm.hour;
			PTR_TWO: tl_val = s.tm.day;
			PTR_THREE: tl_val = s.tm.year;
		endcase
		unique case (s.aptr)
			PTR_ZERO: ah_val = s.al.minute; // [R24]
			PTR_ONE: ah_val = s.al.weekday;
			PTR_TWO: ah_val = s.al.month;
			PTR_THREE: ah_val = RESET_BYTE; // [R15]
		endcase
		unique case (s.aptr)
			PTR_ZERO: al_val = s.al.second; // [R14]
			PTR_ONE: al_val = s.al.hour;
			PTR_TWO: al_val = s.al.day;
			PTR_THREE: al_val = RESET_BYTE;
		endcase

		// Alarm comparison by interval mask.
		match = 1'b0;
		if (tick && s.sub >= half_len) begin
			unique case (s.alarm_interval_mask) // [R25] [R28]
				AM_HALF: match = 1'b1;
				AM_SEC: match = s.half;
				AM_TEN_SEC: match = s.half && s.tm.second[3:0] == s.al.second[3:0];
				AM_MIN: match = s.half && s.tm.second == s.al.second;
				AM_TEN_MIN: match = s.half && s.tm.second == s.al.second
					&& s.tm.minute[3:0] == s.al.minute[3:0];
				AM_HOUR: match = s.half && s.tm.second == s.al.second
					&& s.tm.minute == s.al.minute;
				AM_DAY: match = s.half && {s.tm.second, s.tm.minute, s.tm.hour}
					== {s.al.second, s.al.minute, s.al.hour};
				AM_WEEK: match = s.half && {s.tm.second, s.tm.minute, s.tm.hour,
					s.tm.weekday} == {s.al.second, s.al.minute, s.al.hour,
					s.al.weekday};
				AM_MONTH: match = s.half && {s.tm.second, s.tm.minute, s.tm.hour,
					s.tm.day} == {s.al.second, s.al.minute, s.al.hour, s.al.day};
				AM_YEAR: match = s.half && {s.tm.second, s.tm.minute, s.tm.hour,
					s.tm.day, s.tm.month} == {s.al.second, s.al.minute,
					s.al.hour, s.al.day, s.al.month};
				default: match = 1'b0;
			endcase
		end
		n.alarm_pulse = match && s.alarm_on;
		if (match && s.alarm_on) begin
			if (s.rpt != RESET_BYTE) begin
				n.rpt = s.rpt - 8'h1; // [R11] [R13]
			end else if (s.chime) begin
				n.rpt = COUNT_TOP; // [R10]
			end else begin
				n.alarm_on = 1'b0; // [R12] [R27]
			end
		end

		// Register writes.
		acc_th = (req.wr || req.rd) && req.addr == ADDR_TIME_HIGH;
		acc_ah = (req.wr || req.rd) && req.addr == ADDR_ALARM_HIGH;
		wr_th = req.wr && req.addr == ADDR_TIME_HIGH && s.unlock; // [R23]
		wr_tl = req.wr && req.addr == ADDR_TIME_LOW && s.unlock; // [R17]
		if (req.wr) begin
			unique case (req.addr)
				ADDR_CONFIG_ONE: begin
					if (s.unlock) begin
						n.module_on = wv[BIT_MODULE_ON]; // [R23]
					end
					n.out_on = wv[BIT_OUTPUT_ON];
					n.tptr = wv[1:0];
				end
				ADDR_DRIFT_TRIM: n.trim = wv;
				ADDR_ALARM_CONFIG: begin
					n.alarm_on = wv[BIT_ALARM_ON];
					n.chime = wv[BIT_CHIME];
					n.alarm_interval_mask = wv[5:2];
					n.aptr = wv[1:0];
				end
				ADDR_REPEAT_COUNT: n.rpt = wv;
				ADDR_UNLOCK: begin
					n.ul = UL_IDLE;
					if (wv == UNLOCK_KEY_ONE) begin
						n.ul = UL_FIRST;
					end else if (wv == UNLOCK_KEY_TWO && s.ul == UL_FIRST) begin
						n.unlock = 1'b1; // [R1]
					end else if (wv == LOCK_KEY) begin
						n.unlock = 1'b0; // [R1]
					end
				end
				default: n.ul = s.ul;
			endcase
		end
		if (wr_th) begin
			unique case (s.tptr)
				PTR_ZERO: n.tm.minute = wv & MASK_MIN_SEC;
				PTR_ONE: n.tm.weekday = wv & MASK_WEEKDAY;
				PTR_TWO: n.tm.month = wv & MASK_MONTH;
				PTR_THREE: n.tm.month = s.tm.month; // [R7]
			endcase
		end
		if (wr_tl) begin
			unique case (s.tptr)
				PTR_ZERO: begin
					n.tm.second = wv & MASK_MIN_SEC;
					n.half = 1'b0; // [R3]
					n.sub = 16'h0;
					n.min_secs = 6'd0;
				end
				PTR_ONE: n.tm.hour = wv & MASK_HOUR_DAY;
				PTR_TWO: n.tm.day = wv & MASK_HOUR_DAY;
				PTR_THREE: n.tm.year = wv & MASK_YEAR; // [R16]
			endcase
		end
		if (req.wr && s.unlock && req.addr == ADDR_ALARM_HIGH) begin
			unique case (s.aptr)
				PTR_ZERO: n.al.minute = wv & MASK_MIN_SEC;
				PTR_ONE: n.al.weekday = wv & MASK_WEEKDAY;
				PTR_TWO: n.al.month = wv & MASK_MONTH;
				PTR_THREE: n.al.month = s.al.month;
			endcase
		end
		if (req.wr && s.unlock && req.addr == ADDR_ALARM_LOW) begin
			unique case (s.aptr)
				PTR_ZERO: n.al.second = wv & MASK_MIN_SEC;
				PTR_ONE: n.al.hour = wv & MASK_HOUR_DAY;
				PTR_TWO: n.al.day = wv & MASK_HOUR_DAY;
				PTR_THREE: n.al.day = s.al.day;
			endcase
		end
		if (acc_th && s.tptr != PTR_ZERO) begin
			n.tptr = s.tptr - 2'h1; // [R4] [R7]
		end
		if (acc_ah && s.aptr != PTR_ZERO) begin
			n.aptr = s.aptr - 2'h1; // [R15]
		end

		// Read data stands in the cycle after the read strobe.
		n.rdata = RESET_BYTE;
		if (req.rd) begin
			unique case (req.addr)
				ADDR_CONFIG_ONE: n.rdata = {s.module_on, 1'b0, s.unlock,
					s.ripple, s.half, s.out_on, s.tptr}; // [R2] [R3]
				ADDR_DRIFT_TRIM: n.rdata = s.trim;
				ADDR_CONFIG_TWO: n.rdata = cfg_two_q;
				ADDR_ALARM_CONFIG: n.rdata = {s.alarm_on, s.chime, s.alarm_interval_mask,
					s.aptr};
				ADDR_REPEAT_COUNT: n.rdata = s.rpt;
				ADDR_TIME_HIGH: n.rdata = th_val;
				ADDR_TIME_LOW: n.rdata = tl_val;
				ADDR_ALARM_HIGH: n.rdata = ah_val;
				ADDR_ALARM_LOW: n.rdata = al_val;
				default: n.rdata = RESET_BYTE;
			endcase
		end
		n.clock_out = s.out_on && (cfg_two_q[1] ? s.half : n.alarm_pulse); // [R29]
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s <= '0;
			s.tm.day <= RESET_DAY;
			s.tm.month <= RESET_DAY;
		end else begin
			s <= n;
		end
	end

	// Kept apart from the main state so only power-on reset clears it.
	always_ff @(posedge mclk) begin
		if (!por_n) begin
			cfg_two_q <= RESET_BYTE; // [R9]
		end else if (req.wr && req.addr == ADDR_CONFIG_TWO) begin
			cfg_two_q <= req.wdata;
		end
	end

	assign rdata = s.rdata;
	assign clock_out = s.clock_out;
	assign alarm_pulse = s.alarm_pulse;

endmodule

// file: src/rtw_pkg.sv
// Shared constants, register map and state types for the clock calendar block.
package rtw_pkg;

	// Register indices on the plain register port.
	localparam logic [3:0] ADDR_CONFIG_ONE = 4'h0;
	localparam logic [3:0] ADDR_DRIFT_TRIM = 4'h1;
	localparam logic [3:0] ADDR_CONFIG_TWO = 4'h2;
	localparam logic [3:0] ADDR_ALARM_CONFIG = 4'h3;
	localparam logic [3:0] ADDR_REPEAT_COUNT = 4'h4;
	localparam logic [3:0] ADDR_TIME_HIGH = 4'h5;
	localparam logic [3:0] ADDR_TIME_LOW = 4'h6;
	localparam logic [3:0] ADDR_ALARM_HIGH = 4'h7;
	localparam logic [3:0] ADDR_ALARM_LOW = 4'h8;
	localparam logic [3:0] ADDR_UNLOCK = 4'h9;

	// Unlock sequence: two writes of these keys to the unlock register.
	localparam logic [7:0] UNLOCK_KEY_ONE = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_TWO = 8'haa;
	localparam logic [7:0] LOCK_KEY = 8'h00;

	// Bit positions in the first configuration register.
	localparam int BIT_MODULE_ON = 7;
	localparam int BIT_WRITE_UNLOCK = 5;
	localparam int BIT_RIPPLE = 4;
	localparam int BIT_HALF_SECOND = 3;
	localparam int BIT_OUTPUT_ON = 2;

	// Bit positions in the alarm configuration register.
	localparam int BIT_ALARM_ON = 7;
	localparam int BIT_CHIME = 6;

	// Window pointer codes.
	localparam logic [1:0] PTR_ZERO = 2'h0;
	localparam logic [1:0] PTR_ONE = 2'h1;
	localparam logic [1:0] PTR_TWO = 2'h2;
	localparam logic [1:0] PTR_THREE = 2'h3;

	// Field masks that force unused bits of each slot to zero.
	localparam logic [7:0] MASK_MIN_SEC = 8'h7f;
	localparam logic [7:0] MASK_HOUR_DAY = 8'h3f;
	localparam logic [7:0] MASK_MONTH = 8'h1f;
	localparam logic [7:0] MASK_WEEKDAY = 8'h07;
	localparam logic [7:0] MASK_YEAR = 8'hff;

	// Reset values and the repeat counter wrap value.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] RESET_DAY = 8'h01;
	localparam logic [7:0] COUNT_TOP = 8'hff;

	// Alarm interval mask codes.
	localparam logic [3:0] AM_HALF = 4'h0;
	localparam logic [3:0] AM_SEC = 4'h1;
	localparam logic [3:0] AM_TEN_SEC = 4'h2;
	localparam logic [3:0] AM_MIN = 4'h3;
	localparam logic [3:0] AM_TEN_MIN = 4'h4;
	localparam logic [3:0] AM_HOUR = 4'h5;
	localparam logic [3:0] AM_DAY = 4'h6;
	localparam logic [3:0] AM_WEEK = 4'h7;
	localparam logic [3:0] AM_MONTH = 4'h8;
	localparam logic [3:0] AM_YEAR = 4'h9;

	// Timebase and calibration.
	localparam int TIMEBASE_HZ = 32768;
	localparam int HALF_TICKS = TIMEBASE_HZ / 2;
	localparam int TRIM_STEP = 4;
	localparam logic [3:0] BCD_NINE = 4'h9;

	// Register port request.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rtw_req_t;

	// Calendar time in BCD, one byte per slot.
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] weekday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rtw_time_t;

	// Alarm compare values.
	typedef struct packed {
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] weekday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rtw_alarm_t;

	typedef enum logic [1:0] {
		UL_IDLE,
		UL_FIRST
	} rtw_unlock_t;

endpackage

// file: test/rtw_chk.sv
// Port-level assertions for the clock calendar register block.
`timescale 1ns/1ps
module rtw_chk
	import rtw_pkg::*;
#(
	parameter int TICKS_PER_HALF = HALF_TICKS
) (
	// Clock and resets.
	input wire logic mclk,
	input wire logic rstn,
	input wire logic por_n,
	// Observed ports.
	input wire logic timebase_in,
	input wire rtw_pkg::rtw_req_t req,
	input wire logic [7:0] rdata,
	input wire logic clock_out,
	input wire logic alarm_pulse
);
	import rtw_pkg::*;
	logic [1:0] tptr;
	logic [1:0] aptr;
	logic unl;
	logic first;
	logic ena;
	logic acc;
	logic [7:0] trim;
	assign acc = req.wr | req.rd;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Shadow of the pointers, unlock state, enable and trim seen at the port.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tptr <= 2'h0;
			aptr <= 2'h0;
			unl <= 1'b0;
			first <= 1'b0;
			ena <= 1'b0;
			trim <= 8'h00;
		end else begin
			if (req.wr && req.addr == ADDR_CONFIG_ONE)
				tptr <= req.wdata[1:0];
			else if (acc && req.addr == ADDR_TIME_HIGH && tptr != 2'h0)
				tptr <= tptr - 2'h1;
			if (req.wr && req.addr == ADDR_ALARM_CONFIG)
				aptr <= req.wdata[1:0];
			else if (acc && req.addr == ADDR_ALARM_HIGH && aptr != 2'h0)
				aptr <= aptr - 2'h1;
			if (req.wr && req.addr == ADDR_CONFIG_ONE && unl)
				ena <= req.wdata[BIT_MODULE_ON];
			if (req.wr && req.addr == ADDR_DRIFT_TRIM)
				trim <= req.wdata;
			if (req.wr && req.addr == ADDR_UNLOCK) begin
				first <= req.wdata == UNLOCK_KEY_ONE;
				if (first && req.wdata == UNLOCK_KEY_TWO)
					unl <= 1'b1;
				else if (req.wdata == LOCK_KEY)
					unl <= 1'b0;
			end
		end
	end
	a_pulse_single: assert property (alarm_pulse |-> !$past(alarm_pulse))
		else $error("alarm pulse longer than one cycle");
	a_time_rsvd: assert property (
		req.rd && req.addr == ADDR_TIME_HIGH && tptr == PTR_THREE
		|=> rdata == 8'h00) else $error("reserved time slot not zero");
	a_time_ptr: assert property (
		req.rd && req.addr == ADDR_CONFIG_ONE |=> rdata[1:0] == $past(tptr))
		else $error("time pointer wrong");
	a_alarm_ptr: assert property (
		req.rd && req.addr == ADDR_ALARM_CONFIG
		##1 1'b1 |-> rdata[1:0] == $past(aptr)) else $error("alarm pointer wrong");
	a_alarm_rsvd: assert property (
		req.rd && aptr == PTR_THREE && (req.addr == ADDR_ALARM_HIGH ||
		req.addr == ADDR_ALARM_LOW) |=> rdata == 8'h00)
		else $error("unused alarm slot not zero");
	a_unlock_seq: assert property (
		req.rd && req.addr == ADDR_CONFIG_ONE
		|=> rdata[BIT_WRITE_UNLOCK] == $past(unl)) else $error("unlock bit wrong");
	a_enable_lock: assert property (
		req.rd && req.addr == ADDR_CONFIG_ONE
		|=> rdata[BIT_MODULE_ON] == $past(ena)) else $error("enable bit wrong");
	a_trim_hold: assert property (
		req.rd && req.addr == ADDR_DRIFT_TRIM |=> rdata == $past(trim))
		else $error("trim value wrong");
endmodule

bind rtw_core rtw_chk #(.TICKS_PER_HALF(TICKS_PER_HALF)) u_chk (.mclk(mclk),
	.rstn(rstn), .por_n(por_n), .timebase_in(timebase_in), .req(req),
	.rdata(rdata), .clock_out(clock_out), .alarm_pulse(alarm_pulse));

// file: test/tb_top.sv
// Self-checking bench for the clock calendar register block.
`timescale 1ns/1ps
module tb_top;
	import rtw_pkg::*;
	logic mclk, rstn, por_n, timebase_in, clock_out, alarm_pulse, rd_seen;
	rtw_req_t req;
	logic [7:0] rdata, yr, tr;
	logic [15:0] ent;
	logic [15:0] exp_q[$];
	logic [7:0] wl[4], wh[4], el[4], eh[4];
	int err_total = 0, checked = 0, cycles = 0, pulses = 0, outs = 0;
	int p0, o0;
	rtw_core #(.TICKS_PER_HALF(8)) u_dut (.mclk(mclk), .rstn(rstn),
		.por_n(por_n), .timebase_in(timebase_in), .req(req),
		.rdata(rdata), .clock_out(clock_out), .alarm_pulse(alarm_pulse));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Fast timebase, eight clocks per period, edges 20 ns before a clock edge.
	initial begin
		timebase_in = 1'b0;
		#130;
		forever #400 timebase_in = ~timebase_in;
	end
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatched %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
		exp_q.push_back({e, m});
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
	endtask
	task automatic idle();
		req <= '0;
		@(posedge mclk);
	endtask
	task automatic fin(string n);
		idle();
		$display("test %s done", n);
	endtask
	// Read data stands in the cycle after the read strobe.
	always @(posedge mclk) begin
		cycles++;
		pulses <= pulses + int'(alarm_pulse === 1'b1);
		outs <= outs + int'(clock_out === 1'b1);
		if (rd_seen === 1'b1) begin
			ent = exp_q.pop_front();
			check(rdata & ent[7:0], ent[15:8] & ent[7:0]);
		end
		rd_seen <= req.rd;
		if (cycles > 6000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		req = '0;
		rstn = 1'b0;
		por_n = 1'b0;
		tr = 8'($urandom(32'h6747f957));
		yr = {4'($urandom_range(9)), 4'($urandom_range(9))};
		wl = '{yr, 8'hd8, 8'hd3, 8'hd9};
		wh = '{8'hff, 8'he9, 8'hfd, 8'hc7};
		el = '{yr, 8'h18, 8'h13, 8'h59};
		eh = '{8'h00, 8'h09, 8'h05, 8'h47};
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		por_n <= 1'b1;
		@(posedge mclk);
		for (int a = 0; a < 16; a++)
			if (a != 9)
				rd(4'(a), 8'h00, (a == 0) ? 8'he7 : 8'hff);
		wr(ADDR_CONFIG_ONE, 8'ha0);
		wr(ADDR_TIME_LOW, 8'h45);
		rd(ADDR_CONFIG_ONE, 8'h00, 8'he7);
		rd(ADDR_TIME_LOW, 8'h00);
		fin("locked writes");
		wr(ADDR_UNLOCK, UNLOCK_KEY_ONE);
		wr(ADDR_UNLOCK, UNLOCK_KEY_TWO);
		wr(ADDR_CONFIG_ONE, 8'h03);
		rd(ADDR_CONFIG_ONE, 8'h23, 8'he7);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_TIME_LOW, wl[i]);
			wr(ADDR_TIME_HIGH, wh[i]);
		end
		wr(ADDR_CONFIG_ONE, 8'h23);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_TIME_LOW, el[i]);
			rd(ADDR_TIME_HIGH, eh[i]);
		end
		rd(ADDR_CONFIG_ONE, 8'h20, 8'he7);
		fin("time windows");
		wr(ADDR_ALARM_CONFIG, 8'h02);
		wr(ADDR_ALARM_LOW, 8'hc5);
		wr(ADDR_ALARM_HIGH, 8'hf1);
		rd(ADDR_ALARM_CONFIG, 8'h01);
		wr(ADDR_ALARM_CONFIG, 8'h02);
		rd(ADDR_ALARM_LOW, 8'h05);
		rd(ADDR_ALARM_HIGH, 8'h11);
		wr(ADDR_ALARM_CONFIG, 8'h27);
		rd(ADDR_ALARM_LOW, 8'h00);
		rd(ADDR_ALARM_HIGH, 8'h00);
		rd(ADDR_ALARM_CONFIG, 8'h26);
		fin("alarm windows");
		wr(ADDR_DRIFT_TRIM, tr);
		wr(ADDR_REPEAT_COUNT, 8'ha5);
		wr(ADDR_CONFIG_TWO, 8'h5c);
		rd(ADDR_DRIFT_TRIM, tr);
		rd(ADDR_REPEAT_COUNT, 8'ha5);
		fin("register storage");
		rstn <= 1'b0;
		@(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(ADDR_CONFIG_TWO, 8'h5c);
		rd(ADDR_DRIFT_TRIM, 8'h00);
		idle();
		por_n <= 1'b0;
		@(posedge mclk);
		por_n <= 1'b1;
		@(posedge mclk);
		rd(ADDR_CONFIG_TWO, 8'h00);
		fin("resets");
		wr(ADDR_UNLOCK, UNLOCK_KEY_ONE);
		wr(ADDR_UNLOCK, UNLOCK_KEY_TWO);
		wr(ADDR_REPEAT_COUNT, 8'h02);
		wr(ADDR_ALARM_CONFIG, 8'h80);
		wr(ADDR_CONFIG_ONE, 8'h80);
		idle();
		p0 = pulses;
		repeat (800) @(posedge mclk);
		check(8'(pulses - p0), 8'h03);
		rd(ADDR_ALARM_CONFIG, 8'h00, 8'h80);
		rd(ADDR_REPEAT_COUNT, 8'h00);
		wr(ADDR_REPEAT_COUNT, 8'h01);
		wr(ADDR_ALARM_CONFIG, 8'hc0);
		idle();
		p0 = pulses;
		repeat (800) @(posedge mclk);
		check({7'h00, pulses - p0 > 6}, 8'h01);
		rd(ADDR_ALARM_CONFIG, 8'h80, 8'h80);
		wr(ADDR_TIME_LOW, 8'h09);
		rd(ADDR_CONFIG_ONE, 8'h00, 8'h08);
		idle();
		repeat (150) @(posedge mclk);
		rd(ADDR_TIME_LOW, 8'h10);
		wr(ADDR_CONFIG_TWO, 8'h02);
		wr(ADDR_CONFIG_ONE, 8'h84);
		wr(ADDR_ALARM_CONFIG, 8'hc4);
		idle();
		p0 = pulses;
		o0 = outs;
		repeat (256) @(posedge mclk);
		check(8'(outs - o0), 8'h80);
		check(8'(pulses - p0), 8'h02);
		wr(ADDR_UNLOCK, LOCK_KEY);
		wr(ADDR_CONFIG_ONE, 8'h00);
		rd(ADDR_CONFIG_ONE, 8'h80, 8'ha0);
		fin("alarm run");
		complete_run();
	end
endmodule
